//--- rtl/gpio_port_pkg.sv
// Constants shared by the bidirectional port and its testbench.
// Assumes a 32-bit APB register bus and a single 200 MHz clock.
package gpio_port_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Port geometry.
   localparam int          PORT_WIDTH      = 8;
   localparam int          ADDR_WIDTH      = 12;
   localparam int          DATA_WIDTH      = 32;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets, one aligned word each.
   localparam logic [11:0] OFS_PIN_VALUE   = 12'h000;
   localparam logic [11:0] OFS_OUT_LATCH   = 12'h004;
   localparam logic [11:0] OFS_DIRECTION   = 12'h008;
   localparam logic [11:0] OFS_NEIGHBOR    = 12'h00C;
   localparam logic [11:0] OFS_MEM_CTRL    = 12'h010;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int          PULLUP_EN_BIT   = 5;
   localparam int          EXT_BUS_DIS_BIT = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values. A direction bit of one means input.
   localparam logic [7:0]  LATCH_RESET     = 8'h00;
   localparam logic [7:0]  DIR_RESET       = 8'hFF;
   localparam logic [7:0]  NEIGHBOR_RESET  = 8'h00;
   localparam logic        EXT_DIS_RESET   = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Pin positions of the memory bus control outputs.
   localparam int          PIN_ADDR_LATCH  = 0;
   localparam int          PIN_OUT_EN      = 1;
   localparam int          PIN_WR_LOW      = 2;
   localparam int          PIN_WR_HIGH     = 3;
   localparam int          PIN_BYTE_ADDR   = 4;
   localparam int          PIN_CHIP_EN     = 5;
   localparam int          PIN_LOW_SEL     = 6;
   localparam int          PIN_HIGH_SEL    = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Register select decoded from the APB address.
   typedef enum logic [2:0] {
      SEL_PIN,
      SEL_LATCH,
      SEL_DIR,
      SEL_NEIGHBOR,
      SEL_MEM_CTRL,
      SEL_NONE
   } reg_sel_type;

endpackage : gpio_port_pkg

//--- rtl/port_pin_cell.sv
// One pin of the port: chooses owner, direction and pull-up, and registers them.
// Assumes the memory bus owner flag and all inputs are synchronous to pclk.
`timescale 1ns/10ps
module port_pin_cell (
   input  wire logic pclk,          // System clock.
   input  wire logic presetn,       // Asynchronous reset, active low.
   input  wire logic membus_on,     // Memory interface owns the pin.
   input  wire logic mem_level,     // Level the memory interface wants.
   input  wire logic latch_bit,     // Output latch bit.
   input  wire logic dir_bit,       // Direction bit, one is input.
   input  wire logic pullup_shared, // Shared pull-up enable.
   output logic      pin_out,       // Registered pin drive level.
   output logic      pin_oe,        // Registered pin output enable.
   output logic      pin_pullup     // Registered weak pull-up enable.
);

   logic out_nxt;
   logic oe_nxt;
   logic pullup_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // The memory interface wins over direction and latch.
   always_comb begin
      out_nxt    = membus_on ? mem_level : latch_bit;
      oe_nxt     = membus_on | ~dir_bit;
      pullup_nxt = pullup_shared & ~oe_nxt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out    <= 1'b0;
         pin_oe     <= 1'b0;
         pin_pullup <= 1'b0;
      end else begin
         pin_out    <= out_nxt;
         pin_oe     <= oe_nxt;
         pin_pullup <= pullup_nxt;
      end
   end

endmodule : port_pin_cell

//--- rtl/gpio_membus_port.sv
// Eight-pin bidirectional port with APB registers and memory bus override.
// Assumes APB signals and pin levels are synchronous to pclk.
//
// Operation
// - Eight pins, each able to drive and receive, form one 8-bit port.
// - Each pin owns one direction bit and one output latch bit.
// - Every pin is set as input or output independently of the others.
// - Any reset leaves every pin as a digital input.
// - Each pin has a weak pull-up; shared bit 5 cleared disables all.
// - A pin configured as output has its pull-up switched off.
// - Any reset leaves all pull-ups disabled.
// - Clearing external-bus disable bit 7 hands all pins to the memory interface.
// - Memory interface ignores direction bits and overrides latch data.
// - Pins 0..3 carry address latch, output enable, write low, write high.
// - Pins 4..7 carry byte address, chip enable, low and high byte select.
// - Writing the pin value register stores the value into the output latches.
`timescale 1ns/10ps
module gpio_membus_port (
   input  wire logic        pclk,                // System clock, 200 MHz.
   input  wire logic        presetn,             // Asynchronous reset, active low.
   input  wire logic        psel,                // APB select.
   input  wire logic        penable,             // APB enable.
   input  wire logic        pwrite,              // APB write direction.
   input  wire logic [11:0] paddr,               // APB byte address.
   input  wire logic [31:0] pwdata,              // APB write data.
   input  wire logic [3:0]  pstrb,               // APB byte strobes.
   output logic      [31:0] prdata,              // APB read data.
   output logic             pready,              // APB ready.
   output logic             pslverr,             // APB error on unmapped address.
   input  wire logic [7:0]  pin_in,              // Sampled pin levels.
   output logic      [7:0]  pin_out,             // Pin drive levels.
   output logic      [7:0]  pin_oe,              // Pin output enables, high drives.
   output logic      [7:0]  pin_pullup,          // Weak pull-up enables.
   output logic             ext_bus_active,      // Memory interface owns the pins.
   input  wire logic        mem_addr_latch,      // Address latch enable level.
   input  wire logic        mem_out_en_n,        // Output enable, active low.
   input  wire logic        write_strobe_low,    // Low byte write strobe level.
   input  wire logic        write_strobe_high,   // High byte write strobe level.
   input  wire logic        byte_addr_bit,       // Byte address bit 0.
   input  wire logic        mem_chip_en,         // Chip enable level.
   input  wire logic        low_byte_select,     // Lower byte enable level.
   input  wire logic        high_byte_select_n   // Upper byte enable, active low.
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   logic                       [7:0]  latch_r;
   logic                       [7:0]  dir_r;
   logic                       [7:0]  neighbor_r;
   logic                              ext_dis_r;
   logic                       [31:0] prdata_r;
   logic                       [31:0] prdata_nxt;
   gpio_port_pkg::reg_sel_type        reg_sel;
   logic                              setup_phase;
   logic                              access_phase;
   logic                              wr_en;
   logic                              membus_on;
   logic                              pullup_shared;
   logic                       [7:0]  mem_vec;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode.
   always_comb begin
      case (paddr)
         gpio_port_pkg::OFS_PIN_VALUE: begin
            reg_sel = gpio_port_pkg::SEL_PIN;
         end
         gpio_port_pkg::OFS_OUT_LATCH: begin
            reg_sel = gpio_port_pkg::SEL_LATCH;
         end
         gpio_port_pkg::OFS_DIRECTION: begin
            reg_sel = gpio_port_pkg::SEL_DIR;
         end
         gpio_port_pkg::OFS_NEIGHBOR: begin
            reg_sel = gpio_port_pkg::SEL_NEIGHBOR;
         end
         gpio_port_pkg::OFS_MEM_CTRL: begin
            reg_sel = gpio_port_pkg::SEL_MEM_CTRL;
         end
         default: begin
            reg_sel = gpio_port_pkg::SEL_NONE;
         end
      endcase
   end

   // Read data is captured in the setup cycle, so the slave answers with no wait state
   // while prdata still comes from a flip-flop.
   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign pready       = access_phase;
   assign pslverr      = access_phase & (reg_sel == gpio_port_pkg::SEL_NONE);
   assign wr_en        = access_phase & pwrite & pstrb[0];
   assign prdata       = prdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer.
   always_comb begin
      prdata_nxt = 32'h0000_0000;
      case (reg_sel)
         gpio_port_pkg::SEL_PIN: begin
            prdata_nxt[7:0] = pin_in;
         end
         gpio_port_pkg::SEL_LATCH: begin
            prdata_nxt[7:0] = latch_r;
         end
         gpio_port_pkg::SEL_DIR: begin
            prdata_nxt[7:0] = dir_r;
         end
         gpio_port_pkg::SEL_NEIGHBOR: begin
            prdata_nxt[7:0] = neighbor_r;
         end
         gpio_port_pkg::SEL_MEM_CTRL: begin
            prdata_nxt[gpio_port_pkg::EXT_BUS_DIS_BIT] = ext_dis_r;
         end
         default: begin
            prdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_phase && !pwrite) begin
         prdata_r <= prdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output latches. Both the pin value and the latch register land here, so a
   // read-modify-write of the pin value can copy input levels into the latches.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_r <= gpio_port_pkg::LATCH_RESET;
      end else if (wr_en && (reg_sel == gpio_port_pkg::SEL_PIN)) begin
         latch_r <= pwdata[7:0];
      end else if (wr_en && (reg_sel == gpio_port_pkg::SEL_LATCH)) begin
         latch_r <= pwdata[7:0];
      end
   end

   // Direction bank, one bit per pin.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r <= gpio_port_pkg::DIR_RESET;
      end else if (wr_en && (reg_sel == gpio_port_pkg::SEL_DIR)) begin
         dir_r <= pwdata[7:0];
      end
   end

   // Neighbour register; only the shared pull-up bit steers this port.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         neighbor_r <= gpio_port_pkg::NEIGHBOR_RESET;
      end else if (wr_en && (reg_sel == gpio_port_pkg::SEL_NEIGHBOR)) begin
         neighbor_r <= pwdata[7:0];
      end
   end

   // Memory bus control; the disable bit resets high so pins start as port pins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_dis_r <= gpio_port_pkg::EXT_DIS_RESET;
      end else if (wr_en && (reg_sel == gpio_port_pkg::SEL_MEM_CTRL)) begin
         ext_dis_r <= pwdata[gpio_port_pkg::EXT_BUS_DIS_BIT];
      end
   end

   assign membus_on      = ~ext_dis_r;
   assign ext_bus_active = membus_on;
   assign pullup_shared  = neighbor_r[gpio_port_pkg::PULLUP_EN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Memory interface signal placement. Levels pass through unchanged; the
   // controller owns their polarity.
   always_comb begin
      mem_vec                                = 8'h00;
      mem_vec[gpio_port_pkg::PIN_ADDR_LATCH] = mem_addr_latch;
      mem_vec[gpio_port_pkg::PIN_OUT_EN]     = mem_out_en_n;
      mem_vec[gpio_port_pkg::PIN_WR_LOW]     = write_strobe_low;
      mem_vec[gpio_port_pkg::PIN_WR_HIGH]    = write_strobe_high;
      mem_vec[gpio_port_pkg::PIN_BYTE_ADDR]  = byte_addr_bit;
      mem_vec[gpio_port_pkg::PIN_CHIP_EN]    = mem_chip_en;
      mem_vec[gpio_port_pkg::PIN_LOW_SEL]    = low_byte_select;
      mem_vec[gpio_port_pkg::PIN_HIGH_SEL]   = high_byte_select_n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin cells. Registering the pin drive costs one cycle of latency on memory
   // bus strobes; the controller must account for it.
   for (genvar i = 0; i < gpio_port_pkg::PORT_WIDTH; i++) begin : g_pin
      port_pin_cell u_pin (
         .pclk          (pclk),
         .presetn       (presetn),
         .membus_on     (membus_on),
         .mem_level     (mem_vec[i]),
         .latch_bit     (latch_r[i]),
         .dir_bit       (dir_r[i]),
         .pullup_shared (pullup_shared),
         .pin_out       (pin_out[i]),
         .pin_oe        (pin_oe[i]),
         .pin_pullup    (pin_pullup[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   reset_state_a: assert property (
      $rose(presetn) |-> (pin_oe == 8'h00) && (pin_pullup == 8'h00) && ext_dis_r
   ) else $error("Pins not inputs with pull-ups off after reset.");

   reset_pullup_a: assert property (
      $rose(presetn) |-> !neighbor_r[gpio_port_pkg::PULLUP_EN_BIT]
   ) else $error("Shared pull-up enable set after reset.");

   dir_drive_a: assert property (
      !membus_on |=> (pin_oe == ~$past(dir_r))
   ) else $error("Port pin enable does not follow its direction bit.");

   latch_drive_a: assert property (
      !membus_on |=> (pin_out == $past(latch_r))
   ) else $error("Port pin level does not follow its output latch.");

   membus_owns_a: assert property (
      membus_on |=> (pin_oe == 8'hFF)
   ) else $error("Memory interface mode left a pin undriven.");

   membus_map_a: assert property (
      membus_on |=> (pin_out == $past(mem_vec))
   ) else $error("Memory control signal on the wrong pin.");

   membus_chip_a: assert property (
      membus_on |=> (pin_out[gpio_port_pkg::PIN_CHIP_EN] == $past(mem_chip_en))
   ) else $error("Chip enable not on pin 5.");

   membus_switch_a: assert property (
      (wr_en && (reg_sel == gpio_port_pkg::SEL_MEM_CTRL) && !pwdata[gpio_port_pkg::EXT_BUS_DIS_BIT])
         |=> ##1 (pin_oe == 8'hFF)
   ) else $error("Clearing the bus disable bit did not hand over the pins.");

   pullup_out_a: assert property (
      (pin_pullup & pin_oe) == 8'h00
   ) else $error("Pull-up active on a driven pin.");

   pullup_shared_a: assert property (
      !pullup_shared |=> (pin_pullup == 8'h00)
   ) else $error("Pull-up on while the shared enable is clear.");

   pullup_input_a: assert property (
      (pullup_shared && !membus_on) |=> (pin_pullup == $past(dir_r))
   ) else $error("Pull-up does not follow input pins with shared enable set.");

   pin_write_a: assert property (
      (wr_en && (reg_sel == gpio_port_pkg::SEL_PIN)) |=> (latch_r == $past(pwdata[7:0]))
   ) else $error("Pin value write did not reach the output latches.");

   pin_read_a: assert property (
      (setup_phase && !pwrite && (reg_sel == gpio_port_pkg::SEL_PIN))
         |=> (prdata == {24'h00_0000, $past(pin_in)})
   ) else $error("Pin value read did not return the sampled pin levels.");

   unmapped_err_a: assert property (
      (access_phase && (reg_sel == gpio_port_pkg::SEL_NONE)) |-> pslverr && pready
         ##1 (dir_r == $past(dir_r)) && (neighbor_r == $past(neighbor_r)) && (ext_dis_r == $past(ext_dis_r))
   ) else $error("Unmapped access not refused, or it changed a register.");

   reset_regs_a: assert property (
      $rose(presetn) |-> (dir_r == gpio_port_pkg::DIR_RESET) && (latch_r == gpio_port_pkg::LATCH_RESET)
   ) else $error("Direction or latch bank not at its reset value.");

   latch_write_a: assert property (
      (wr_en && (reg_sel == gpio_port_pkg::SEL_LATCH)) |=> (latch_r == $past(pwdata[7:0]))
   ) else $error("Latch write did not reach the output latches.");

   dir_write_a: assert property (
      (wr_en && (reg_sel == gpio_port_pkg::SEL_DIR)) |=> (dir_r == $past(pwdata[7:0]))
   ) else $error("Direction write did not reach the direction bank.");

   neighbor_write_a: assert property (
      (wr_en && (reg_sel == gpio_port_pkg::SEL_NEIGHBOR)) |=> (neighbor_r == $past(pwdata[7:0]))
   ) else $error("Neighbour write did not reach its register.");

   memctrl_write_a: assert property (
      (wr_en && (reg_sel == gpio_port_pkg::SEL_MEM_CTRL))
         |=> (ext_dis_r == $past(pwdata[gpio_port_pkg::EXT_BUS_DIS_BIT]))
   ) else $error("Bus disable write did not reach its bit.");

   latch_hold_a: assert property (
      !(wr_en && ((reg_sel == gpio_port_pkg::SEL_PIN) || (reg_sel == gpio_port_pkg::SEL_LATCH)))
         |=> (latch_r == $past(latch_r))
   ) else $error("Output latches changed without a write.");

   dir_hold_a: assert property (
      !(wr_en && (reg_sel == gpio_port_pkg::SEL_DIR)) |=> (dir_r == $past(dir_r))
   ) else $error("Direction bank changed without a write.");

   read_hold_a: assert property (
      !(setup_phase && !pwrite) |=> (prdata == $past(prdata))
   ) else $error("Read data changed outside a read setup cycle.");

   latch_read_a: assert property (
      (setup_phase && !pwrite && (reg_sel == gpio_port_pkg::SEL_LATCH))
         |=> (prdata == {24'h00_0000, $past(latch_r)})
   ) else $error("Latch read did not return the output latches.");

   dir_read_a: assert property (
      (setup_phase && !pwrite && (reg_sel == gpio_port_pkg::SEL_DIR))
         |=> (prdata == {24'h00_0000, $past(dir_r)})
   ) else $error("Direction read did not return the direction bank.");

   neighbor_read_a: assert property (
      (setup_phase && !pwrite && (reg_sel == gpio_port_pkg::SEL_NEIGHBOR))
         |=> (prdata == {24'h00_0000, $past(neighbor_r)})
   ) else $error("Neighbour read did not return its register.");

   memctrl_read_a: assert property (
      (setup_phase && !pwrite && (reg_sel == gpio_port_pkg::SEL_MEM_CTRL))
         |=> (prdata == {24'h00_0000, $past(ext_dis_r), 7'h00})
   ) else $error("Memory bus control read returned a wrong word.");

   unmapped_read_a: assert property (
      (setup_phase && !pwrite && (reg_sel == gpio_port_pkg::SEL_NONE))
         |=> (prdata == 32'h0000_0000)
   ) else $error("Unmapped read returned non-zero data.");

   membus_pullup_a: assert property (
      membus_on |=> (pin_pullup == 8'h00)
   ) else $error("Pull-up active while the memory interface drives the pins.");

   dir_cover_c: cover property (
      wr_en && (reg_sel == gpio_port_pkg::SEL_DIR) && (pwdata[7:0] != 8'hFF)
   );

   membus_cover_c: cover property (
      !membus_on ##1 membus_on ##2 (pin_oe == 8'hFF)
   );

   pullup_cover_c: cover property (
      pin_pullup != 8'h00
   );

   pin_read_cover_c: cover property (
      access_phase && !pwrite && (reg_sel == gpio_port_pkg::SEL_PIN)
   );

endmodule : gpio_membus_port

//--- testbench/port_far_side.sv
// Far side of the port: memory controller levels and the board wires on the eight pins.
// Assumes the bench changes board drive and controller levels just after a rising edge.
`timescale 1ns/10ps
module port_far_side (
   input  wire logic       pclk,               // System clock.
   input  wire logic       presetn,            // Asynchronous reset, active low.
   input  wire logic [7:0] pin_out,            // Port drive levels.
   input  wire logic [7:0] pin_oe,             // Port output enables.
   input  wire logic [7:0] pin_pullup,         // Port weak pull-ups.
   input  wire logic [7:0] ext_en,             // Board driver enables.
   input  wire logic [7:0] ext_val,            // Board driver levels.
   input  wire logic [7:0] mem_val,            // Controller levels in pin order.
   output logic      [7:0] pin_in,             // Resolved wire levels.
   output logic            mem_addr_latch,     // Address latch enable.
   output logic            mem_out_en_n,       // Output enable.
   output logic            write_strobe_low,   // Low byte write strobe.
   output logic            write_strobe_high,  // High byte write strobe.
   output logic            byte_addr_bit,      // Byte address bit 0.
   output logic            mem_chip_en,        // Chip enable.
   output logic            low_byte_select,    // Lower byte enable.
   output logic            high_byte_select_n  // Upper byte enable.
);
   logic [7:0] last_r;
   logic [7:0] ctrl_r;

   ////////////////////////////////////////////////////////////////////////////
   // A floating wire shows the inverse of its last level, so a stale value never reads back as valid.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & pin_pullup)
                 | (~pin_oe & ~ext_en & ~pin_pullup & ~last_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         last_r <= 8'h00;
      else
         last_r <= pin_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_r <= 8'h00;
      else
         ctrl_r <= mem_val;
   end

   assign mem_addr_latch     = ctrl_r[0];
   assign mem_out_en_n       = ctrl_r[1];
   assign write_strobe_low   = ctrl_r[2];
   assign write_strobe_high  = ctrl_r[3];
   assign byte_addr_bit      = ctrl_r[4];
   assign mem_chip_en        = ctrl_r[5];
   assign low_byte_select    = ctrl_r[6];
   assign high_byte_select_n = ctrl_r[7];
endmodule : port_far_side

//--- testbench/tb_top.sv
// Self-checking bench for the bidirectional port, driven over APB.
// Assumes zero-wait APB answers and pin outputs one clock behind their registers.
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
   $display("ERROR %s expected %h seen %h", what, exp, got); end end
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, ext_bus_active, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0]  pstrb;
   logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val, mem_val, dir;
   logic        m0, m1, m2, m3, m4, m5, m6, m7;
   int          errors, checks, cycles;

   gpio_membus_port gpio_membus_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .ext_bus_active(ext_bus_active), .mem_addr_latch(m0), .mem_out_en_n(m1), .write_strobe_low(m2),
      .write_strobe_high(m3), .byte_addr_bit(m4), .mem_chip_en(m5), .low_byte_select(m6),
      .high_byte_select_n(m7));
   port_far_side port_far_side_inst (.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .mem_val(mem_val), .pin_in(pin_in),
      .mem_addr_latch(m0), .mem_out_en_n(m1), .write_strobe_low(m2), .write_strobe_high(m3),
      .byte_addr_bit(m4), .mem_chip_en(m5), .low_byte_select(m6), .high_byte_select_n(m7));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   // A hung handshake would otherwise stall the run forever.
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic [3:0] strb);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wd;
      pstrb   <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
      apb(1'b1, addr, wd, 4'hF);
   endtask : wr

   task automatic rd_check(input string what, input logic [11:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0000_0000, 4'h0);
      `CHECK(what, exp, rdata)
   endtask : rd_check

   // Pins follow their registers one clock later; three edges leave margin for the controller stage.
   task automatic settle();
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask : settle

   task automatic board(input logic [7:0] en, input logic [7:0] val, input logic [7:0] mem);
      @(posedge pclk);
      ext_en  <= en;
      ext_val <= val;
      mem_val <= mem;
   endtask : board

   task automatic reset_check();
      @(negedge pclk);
      `CHECK("oe_rst", 8'h00, pin_oe)
      `CHECK("pu_rst", 8'h00, pin_pullup)
      `CHECK("ext_rst", 1'b0, ext_bus_active)
      rd_check("dir_rst", gpio_port_pkg::OFS_DIRECTION, 32'h0000_00FF);
      rd_check("lat_rst", gpio_port_pkg::OFS_OUT_LATCH, 32'h0000_0000);
      rd_check("nb_rst", gpio_port_pkg::OFS_NEIGHBOR, 32'h0000_0000);
      rd_check("mc_rst", gpio_port_pkg::OFS_MEM_CTRL, 32'h0000_0080);
   endtask : reset_check

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn <= 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= '0;
      {ext_en, ext_val, mem_val} <= '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      reset_check();
      dir = 8'hCF;
      wr(gpio_port_pkg::OFS_DIRECTION, {24'h00_0000, dir});
      wr(gpio_port_pkg::OFS_PIN_VALUE, 32'h0000_00A5);
      board(dir, 8'h5A, 8'h00);
      settle();
      `CHECK("oe_mix", ~dir, pin_oe)
      `CHECK("out_lat", 8'hA5, pin_out)
      `CHECK("pu_off", 8'h00, pin_pullup)
      rd_check("lat_rb", gpio_port_pkg::OFS_OUT_LATCH, 32'h0000_00A5);
      rd_check("pin_rb", gpio_port_pkg::OFS_PIN_VALUE, {24'h00_0000, (8'h5A & dir) | (8'hA5 & ~dir)});
      wr(gpio_port_pkg::OFS_NEIGHBOR, 32'h0000_0020);
      settle();
      `CHECK("pu_on", dir, pin_pullup)
      apb(1'b1, gpio_port_pkg::OFS_OUT_LATCH, 32'h0000_00FF, 4'h0);
      rd_check("lat_strb", gpio_port_pkg::OFS_OUT_LATCH, 32'h0000_00A5);
      for (int i = 0; i < 8; i++) begin
         wr(gpio_port_pkg::OFS_DIRECTION, {24'h00_0000, ~(8'h01 << i)});
         settle();
         `CHECK("oe_one", 8'h01 << i, pin_oe)
         `CHECK("pu_one", ~(8'h01 << i), pin_pullup)
      end
      wr(gpio_port_pkg::OFS_PIN_VALUE, 32'h0000_0000);
      rd_check("lat_clr", gpio_port_pkg::OFS_OUT_LATCH, 32'h0000_0000);
      wr(gpio_port_pkg::OFS_OUT_LATCH, 32'h0000_00C3);
      wr(gpio_port_pkg::OFS_MEM_CTRL, 32'h0000_0000);
      settle();
      `CHECK("ext_on", 1'b1, ext_bus_active)
      `CHECK("oe_mem", 8'hFF, pin_oe)
      `CHECK("pu_mem", 8'h00, pin_pullup)
      for (int i = 0; i < 8; i++) begin
         board(8'h00, 8'h00, 8'h01 << i);
         settle();
         `CHECK("mem_pin", 8'h01 << i, pin_out)
      end
      board(8'h00, 8'h00, 8'h96);
      settle();
      `CHECK("mem_mix", 8'h96, pin_out)
      wr(gpio_port_pkg::OFS_MEM_CTRL, 32'h0000_0080);
      settle();
      `CHECK("ext_off", 1'b0, ext_bus_active)
      `CHECK("oe_back", 8'h80, pin_oe)
      `CHECK("out_back", 8'hC3, pin_out)
      apb(1'b1, 12'h100, 32'h0000_00FF, 4'hF);
      `CHECK("slverr_w", 1'b1, err)
      apb(1'b0, 12'h100, 32'h0000_0000, 4'h0);
      `CHECK("slverr_r", 1'b1, err)
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      reset_check();
      wrap_up();
   end
endmodule : tb_top
